// file: core/peak_hold_lamp.sv
`timescale 1ns/1ps
`default_nettype none
module peak_hold_lamp #(
  parameter int CNT_W = 32,
  parameter logic [CNT_W-1:0] HOLD_COUNT = CNT_W'(track_panel_pkg::HOLD_CYCLES)
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clockEnable,
  input wire logic [2:0] holdMode,
  input wire logic clearPulse,
  input wire logic modeChange,
  input wire logic peakEvent,
  output logic peakLamp
);

  typedef struct packed {
    logic lamp;
    logic [CNT_W-1:0] count;
  } hold_state_t;

  hold_state_t state_reg;
  hold_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (peakEvent) begin
      state_next.lamp = 1'b1;
      state_next.count = HOLD_COUNT;
    end else begin
      case (holdMode)
        track_panel_pkg::HOLD_CONT: begin
          if (clearPulse || modeChange) begin // [R9] [R12]
            state_next.lamp = 1'b0;
          end
        end
        track_panel_pkg::HOLD_MOM: begin
          if (clearPulse || modeChange || state_reg.count <= CNT_W'(1)) begin // [R10] [R12]
            state_next.lamp = 1'b0;
            state_next.count = '0;
          end else begin
            state_next.count = state_reg.count - CNT_W'(1);
          end
        end
        default: begin
          // Off: lamp only shows the live peak, nothing is held
          state_next.lamp = 1'b0; // [R11] [R16]
          state_next.count = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0; // [R21]
    end else if (clockEnable) begin
      state_reg <= state_next;
    end
  end

  assign peakLamp = state_reg.lamp;

endmodule : peak_hold_lamp
`default_nettype wire

// file: core/track_monitor_meter_control.sv
`timescale 1ns/1ps
`default_nettype none
module track_monitor_meter_control #(
  parameter int TRACKS = track_panel_pkg::TRACKS,
  parameter int CNT_W = 32,
  parameter logic [CNT_W-1:0] HOLD_COUNT = CNT_W'(track_panel_pkg::HOLD_CYCLES),
  parameter logic [CNT_W-1:0] MESSAGE_COUNT = CNT_W'(track_panel_pkg::MESSAGE_CYCLES),
  parameter logic [CNT_W-1:0] FLASH_COUNT = CNT_W'(track_panel_pkg::FLASH_CYCLES)
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clockEnable,
  input wire logic autoButton,
  input wire logic allButton,
  input wire logic peakModeButton,
  input wire logic peakClearButton,
  input wire logic [TRACKS-1:0] armButton,
  input wire logic [5:0] transport,
  input wire logic trackCopyMode,
  input wire logic [TRACKS-1:0] peakEvent,
  input wire logic [TRACKS-1:0] clipEvent,
  output logic [TRACKS-1:0] monitorInput,
  output logic [TRACKS-1:0] inputLamp,
  output logic [TRACKS-1:0] arm_lamp,
  output logic [TRACKS-1:0] recording,
  output logic [TRACKS-1:0] peakLamp,
  output logic [TRACKS-1:0] clipLamp,
  output logic autoLamp,
  output logic allLamp,
  output logic [2:0] holdModeLamp,
  output logic fineMeterMode,
  output logic fine_scale_message
);

  localparam int NB = track_panel_pkg::BUTTONS - 8 + TRACKS;

  typedef struct packed {
    logic [NB-1:0] sync1;
    logic [NB-1:0] sync2;
    logic [NB-1:0] sync3;
    logic [NB-1:0] stable;
    logic autoOn;
    logic allOn;
    logic fineOn;
    logic [2:0] holdMode;
    logic [TRACKS-1:0] armed;
    logic [CNT_W-1:0] msgCount;
    logic msgOn;
    logic [CNT_W-1:0] flashCount;
    logic flashPhase;
    logic [TRACKS-1:0] monSel;
    logic [TRACKS-1:0] inLamp;
    logic [TRACKS-1:0] armLamp;
    logic [TRACKS-1:0] recOn;
    logic [TRACKS-1:0] clip;
  } panel_state_t;

  panel_state_t state_reg;
  panel_state_t state_next;

  logic [NB-1:0] buttonsRaw;
  logic [NB-1:0] stableNew;
  logic [NB-1:0] press;
  logic [2:0] holdEffective;
  logic holdModeChange;
  logic peakClearPulse;

  assign buttonsRaw = {armButton, peakClearButton, peakModeButton, allButton, autoButton};

  // A change only counts once the second and third stages agree
  assign stableNew = (state_reg.sync2 & state_reg.sync3)
                   | (state_reg.stable & (state_reg.sync2 | state_reg.sync3));
  assign press = stableNew & ~state_reg.stable;

  always_comb begin
    logic inPlay;
    logic inRecord;
    logic bothMeter;
    logic anyMeter;
    logic [2:0] holdNext;
    logic [TRACKS-1:0] sel;
    inPlay = (transport == track_panel_pkg::TR_PLAY);
    inRecord = (transport == track_panel_pkg::TR_RECORD);
    bothMeter = stableNew[track_panel_pkg::BTN_PEAK_MODE] && stableNew[track_panel_pkg::BTN_PEAK_CLEAR]
              && (press[track_panel_pkg::BTN_PEAK_MODE] || press[track_panel_pkg::BTN_PEAK_CLEAR]);
    anyMeter = press[track_panel_pkg::BTN_PEAK_MODE] || press[track_panel_pkg::BTN_PEAK_CLEAR];
    holdNext = state_reg.holdMode;
    sel = '0;
    holdModeChange = 1'b0;
    peakClearPulse = 1'b0;

    state_next = state_reg;
    state_next.sync1 = buttonsRaw;
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    state_next.stable = stableNew;

    if (press[track_panel_pkg::BTN_AUTO]) begin
      state_next.autoOn = ~state_reg.autoOn; // [R1]
    end

    // Track copy forces all-input off and keeps it off while active
    if (trackCopyMode) begin
      state_next.allOn = 1'b0; // [R7]
    end else if (press[track_panel_pkg::BTN_ALL]) begin
      state_next.allOn = ~state_reg.allOn;
    end

    // Meter buttons: a simultaneous pair enters fine mode; a lone press leaves it
    if (bothMeter && !state_reg.fineOn) begin
      state_next.fineOn = 1'b1; // [R13]
      state_next.msgOn = 1'b1;
      state_next.msgCount = MESSAGE_COUNT;
    end else if (state_reg.fineOn) begin
      if (anyMeter && !bothMeter) begin
        state_next.fineOn = 1'b0; // [R13]
      end
    end else if (press[track_panel_pkg::BTN_PEAK_MODE] && !stableNew[track_panel_pkg::BTN_PEAK_CLEAR]) begin
      case (state_reg.holdMode)
        track_panel_pkg::HOLD_CONT: holdNext = track_panel_pkg::HOLD_MOM; // [R8]
        track_panel_pkg::HOLD_MOM: holdNext = track_panel_pkg::HOLD_OFF; // [R8]
        track_panel_pkg::HOLD_OFF: holdNext = track_panel_pkg::HOLD_CONT; // [R8]
        default: holdNext = track_panel_pkg::HOLD_RESET;
      endcase
      holdModeChange = 1'b1; // [R9]
    end else if (press[track_panel_pkg::BTN_PEAK_CLEAR] && !stableNew[track_panel_pkg::BTN_PEAK_MODE]) begin
      peakClearPulse = 1'b1; // [R12]
    end
    state_next.holdMode = holdNext;
    // Leaving fine mode restores holding; count it as a mode change to drop stale lamps
    if (state_reg.fineOn && !state_next.fineOn) begin
      holdModeChange = 1'b1;
    end

    if (state_reg.msgOn) begin
      if (state_reg.msgCount <= CNT_W'(1)) begin
        state_next.msgOn = 1'b0;
        state_next.msgCount = '0;
      end else begin
        state_next.msgCount = state_reg.msgCount - CNT_W'(1);
      end
    end
    if (!state_next.fineOn) begin
      state_next.msgOn = 1'b0;
    end

    // Arm presses toggle record-ready in every transport state, record included
    state_next.armed = state_reg.armed
                     ^ press[track_panel_pkg::BTN_ARM_LSB +: TRACKS]; // [R17] [R19] [R20]

    // Monitor source per track, from the next armed set so lamp and audio move together
    for (int t = 0; t < TRACKS; t++) begin
      if (state_next.allOn) begin
        sel[t] = 1'b1; // [R6]
      end else if (state_next.autoOn) begin
        sel[t] = state_next.armed[t] && !inPlay; // [R3] [R5]
      end else begin
        sel[t] = state_next.armed[t]; // [R2]
      end
    end
    state_next.monSel = sel;
    state_next.inLamp = sel; // [R4] [R17]

    if (state_reg.flashCount <= CNT_W'(1)) begin
      state_next.flashCount = FLASH_COUNT;
      state_next.flashPhase = ~state_reg.flashPhase;
    end else begin
      state_next.flashCount = state_reg.flashCount - CNT_W'(1);
    end

    state_next.recOn = inRecord ? state_next.armed : '0; // [R18]
    for (int t = 0; t < TRACKS; t++) begin
      if (!state_next.armed[t]) begin
        state_next.armLamp[t] = 1'b0; // [R19]
      end else if (inRecord) begin
        state_next.armLamp[t] = 1'b1; // [R18]
      end else begin
        state_next.armLamp[t] = state_next.flashPhase; // [R17]
      end
    end

    state_next.clip = clipEvent; // [R15]
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0; // [R21]
      state_reg.holdMode <= track_panel_pkg::HOLD_RESET;
      state_reg.flashCount <= FLASH_COUNT;
    end else if (clockEnable) begin
      state_reg <= state_next;
    end
  end

  // Fine mode forces hold off without losing the chosen mode
  assign holdEffective = state_reg.fineOn ? track_panel_pkg::HOLD_OFF : state_reg.holdMode; // [R16]

  for (genvar t = 0; t < TRACKS; t++) begin : g_peak
    peak_hold_lamp #(
      .CNT_W(CNT_W),
      .HOLD_COUNT(HOLD_COUNT)
    ) u_hold (
      .clock(clock),
      .arst_n(arst_n),
      .clockEnable(clockEnable),
      .holdMode(holdEffective),
      .clearPulse(peakClearPulse),
      .modeChange(holdModeChange),
      .peakEvent(peakEvent[t]),
      .peakLamp(peakLamp[t])
    );
  end

  assign monitorInput = state_reg.monSel;
  assign inputLamp = state_reg.inLamp;
  assign arm_lamp = state_reg.armLamp;
  assign recording = state_reg.recOn;
  assign clipLamp = state_reg.clip;
  assign autoLamp = state_reg.autoOn;
  assign allLamp = state_reg.allOn;
  assign holdModeLamp = state_reg.holdMode;
  // Meter scaler uses this flag for the 0.5 dB fine scale around -15 dB
  assign fineMeterMode = state_reg.fineOn; // [R14]
  assign fine_scale_message = state_reg.msgOn; // [R13]

endmodule : track_monitor_meter_control
`default_nettype wire

// file: core/track_panel_pkg.sv
// Overview of operation
// [R1]: Each auto-monitor press toggles automatic input monitoring.
// [R2]: Auto and all-input off: armed tracks hear input, others tape, always.
// [R3]: Auto on: armed tracks hear input except during play; unarmed hear tape.
// [R4]: Input lamp lit exactly while the track's output selects input.
// [R5]: Under auto, a track switches to input on punch-in, back on punch-out.
// [R6]: All-input on overrides everything: every track hears input, lamps lit.
// [R7]: Track-copy mode clears all-input monitoring and its lamp.
// [R8]: Hold-mode button cycles continuous, momentary, off, continuous.
// [R9]: Continuous hold keeps a peak lamp lit until clear or mode change.
// [R10]: Momentary hold keeps a peak lamp lit about two seconds.
// [R11]: Off hold mode holds no peak lamp.
// [R12]: Peak clear drops held lamps in continuous or momentary; none in off.
// [R13]: Both meter buttons enter fine mode with message; either alone leaves.
// [R14]: Fine mode rescales meters to 0.5 dB steps, -18 to -12.5 dB.
// [R15]: Clip lamps keep indicating clipping in fine mode.
// [R16]: Fine mode disables peak hold as if hold mode were off.
// [R17]: First arm press makes track ready, lamp flashing, input lamp per monitor.
// [R18]: Entering record turns ready tracks to recording, lamp steady.
// [R19]: Second arm press cancels ready and darkens the arm lamp.
// [R20]: Arm presses are accepted in record mode for on-the-fly punching.
// [R21]: Reset: auto, all-input, fine off; nothing armed; peak lamps cleared.
package track_panel_pkg;

  localparam int TRACKS = 8;
  localparam longint CLOCK_HZ = 250000000;
  localparam longint HOLD_MS = 2000;
  localparam longint HOLD_CYCLES = (HOLD_MS * CLOCK_HZ) / 1000;
  localparam longint MESSAGE_MS = 1000;
  localparam longint MESSAGE_CYCLES = (MESSAGE_MS * CLOCK_HZ) / 1000;
  localparam longint FLASH_MS = 250;
  localparam longint FLASH_CYCLES = (FLASH_MS * CLOCK_HZ) / 1000;

  // Button vector layout after the synchroniser
  localparam int BTN_AUTO = 0;
  localparam int BTN_ALL = 1;
  localparam int BTN_PEAK_MODE = 2;
  localparam int BTN_PEAK_CLEAR = 3;
  localparam int BTN_ARM_LSB = 4;
  localparam int BUTTONS = 12;

  // Fine scale: centre -15 dB, 0.5 dB steps, -18.0 to -12.5 dB, in tenths of dB
  localparam int FINE_CENTRE_DB10 = -150;
  localparam int FINE_STEP_DB10 = 5;
  localparam int FINE_LOW_DB10 = -180;
  localparam int FINE_HIGH_DB10 = -125;

  typedef enum logic [5:0] {
    TR_STOP = 6'h01,
    TR_PAUSE = 6'h02,
    TR_REWIND = 6'h04,
    TR_FFWD = 6'h08,
    TR_PLAY = 6'h10,
    TR_RECORD = 6'h20
  } transport_t;

  typedef enum logic [2:0] {
    HOLD_CONT = 3'h1,
    HOLD_MOM = 3'h2,
    HOLD_OFF = 3'h4
  } hold_mode_t;

  localparam hold_mode_t HOLD_RESET = HOLD_CONT;

endpackage : track_panel_pkg

// file: tb/panel_partner.sv
`timescale 1ns/1ps
`default_nettype none
module panel_partner (
  input wire logic clock,
  output logic [11:0] buttons
);
  initial buttons = '0;
  // Held and released long enough to pass the synchroniser both ways
  task automatic press(input logic [11:0] mask);
    @(negedge clock) buttons = mask;
    repeat (6) @(negedge clock);
    buttons = '0;
    repeat (6) @(negedge clock);
  endtask : press
endmodule : panel_partner
`default_nettype wire

// file: tb/track_monitor_meter_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module track_monitor_meter_control_sva #(
  parameter int CNT_W = 32,
  parameter logic [CNT_W-1:0] HOLD_COUNT = 20
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [5:0] transport,
  input wire logic trackCopyMode,
  input wire logic [7:0] peakEvent,
  input wire logic [7:0] clipEvent,
  input wire logic [7:0] monitorInput,
  input wire logic [7:0] inputLamp,
  input wire logic [7:0] arm_lamp,
  input wire logic [7:0] recording,
  input wire logic [7:0] peakLamp,
  input wire logic [7:0] clipLamp,
  input wire logic autoLamp,
  input wire logic allLamp,
  input wire logic [2:0] holdModeLamp,
  input wire logic fineMeterMode,
  input wire logic fine_scale_message
);
  logic [7:0] quiet;
  // Cycles since track 0 last saw a peak, saturating
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) quiet <= '0;
    else if (peakEvent[0]) quiet <= '0;
    else if (quiet != 8'hff) quiet <= quiet + 8'h01;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_lamp_tracks_sel: assert property (inputLamp == monitorInput)
    else $error("input lamp differs from monitor select");
  a_all_overrides: assert property (allLamp && $past(allLamp) |-> monitorInput == 8'hff)
    else $error("all-input on but a track hears tape");
  a_copy_clears_all: assert property (trackCopyMode |=> !allLamp)
    else $error("all-input lamp on during track copy");
  a_auto_play_tape: assert property ((autoLamp && !allLamp && transport == 6'h10)[*2] |-> monitorInput == 8'h00)
    else $error("auto monitor in play selects input");
  a_rec_lamp_steady: assert property ((recording & ~arm_lamp) == 8'h00)
    else $error("recording track without steady arm lamp");
  a_rec_needs_record: assert property (transport != 6'h20 |=> recording == 8'h00)
    else $error("recording outside record mode");
  a_clip_follows: assert property ($past(arst_n) |-> clipLamp == $past(clipEvent))
    else $error("clip lamp not one cycle after clip");
  a_fine_no_hold: assert property (fineMeterMode && $past(fineMeterMode) |-> peakLamp == $past(peakEvent))
    else $error("peak held in fine mode");
  a_off_no_hold: assert property (holdModeLamp == 3'h4 && $past(holdModeLamp) == 3'h4 && $past(arst_n)
    |-> peakLamp == $past(peakEvent))
    else $error("peak held in off mode");
  a_mom_release: assert property (holdModeLamp == 3'h2 && 32'(quiet) > HOLD_COUNT + 3 |-> !peakLamp[0])
    else $error("momentary peak held too long");
  a_msg_in_fine: assert property (fine_scale_message |-> fineMeterMode)
    else $error("fine message outside fine mode");
  a_hold_onehot: assert property ($onehot(holdModeLamp))
    else $error("hold mode lamp not one-hot");
  c_fine: cover property ($rose(fineMeterMode));
  c_rec: cover property (recording != 8'h00);
  c_all: cover property (allLamp);
  c_mom: cover property (holdModeLamp == 3'h2 && peakLamp[0]);
endmodule : track_monitor_meter_control_sva
bind track_monitor_meter_control track_monitor_meter_control_sva #(.CNT_W(CNT_W), .HOLD_COUNT(HOLD_COUNT)) sva_i (
  .clock, .arst_n, .transport, .trackCopyMode, .peakEvent, .clipEvent, .monitorInput, .inputLamp, .arm_lamp,
  .recording, .peakLamp, .clipLamp, .autoLamp, .allLamp, .holdModeLamp, .fineMeterMode, .fine_scale_message);
`default_nettype wire

// file: tb/track_monitor_meter_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module track_monitor_meter_control_tb;
  logic clock = 0, arst_n = 0, trackCopyMode, autoOn, allOn, autoLamp, allLamp, fineMeterMode, fine_scale_message;
  logic clockEnable;
  logic [5:0] transport;
  logic [2:0] holdModeLamp;
  logic [11:0] buttons;
  logic [7:0] peakEvent, clipEvent, armed, m, monitorInput, inputLamp, arm_lamp, recording, peakLamp, clipLamp;
  int bad_count = 0, check_count = 0, cycles = 0;
  always #2 clock = ~clock;
  panel_partner panel_partner_i (.clock, .buttons);
  track_monitor_meter_control #(.HOLD_COUNT(20), .MESSAGE_COUNT(40), .FLASH_COUNT(4)) track_monitor_meter_control_i (
    .clock, .arst_n, .clockEnable, .autoButton(buttons[0]), .allButton(buttons[1]),
    .peakModeButton(buttons[2]), .peakClearButton(buttons[3]), .armButton(buttons[11:4]), .transport,
    .trackCopyMode, .peakEvent, .clipEvent, .monitorInput, .inputLamp, .arm_lamp, .recording, .peakLamp,
    .clipLamp, .autoLamp, .allLamp, .holdModeLamp, .fineMeterMode, .fine_scale_message);
  function automatic logic [7:0] expSel(input logic [5:0] tr);
    if (allOn) return 8'hff;
    return (autoOn && tr == 6'h10) ? 8'h00 : armed;
  endfunction : expSel
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic sweep;
    for (int i = 0; i < 6; i++) begin
      transport = 6'h01 << i;
      tick(2);
      check(monitorInput, expSel(transport));
      check(inputLamp, expSel(transport));
      check(recording, (i == 5) ? armed : 8'h00);
    end
  endtask : sweep
  task automatic pulse(input logic [7:0] v);
    peakEvent = v;
    clipEvent = v;
    tick(1);
    check(clipLamp, v);
    peakEvent = '0;
    clipEvent = '0;
  endtask : pulse
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h629d));
    transport = 6'h01;
    peakEvent = '0;
    clipEvent = '0;
    trackCopyMode = 0;
    clockEnable = 1;
    {autoOn, allOn, armed} = '0;
    tick(4);
    arst_n = 1;
    tick(2);
    check({5'h0, autoLamp, allLamp, fineMeterMode}, 8'h00);
    check(arm_lamp | peakLamp | monitorInput, 8'h00);
    check(8'(holdModeLamp), 8'h01);
    // A press made while the clock enable is low must leave no trace
    clockEnable = 0;
    panel_partner_i.press(12'h001);
    clockEnable = 1;
    tick(6);
    check(8'(autoLamp), 8'h00);
    armed = 8'($urandom) | 8'h01;
    panel_partner_i.press({armed, 4'h0});
    sweep();
    panel_partner_i.press(12'h001);
    autoOn = 1;
    check(8'(autoLamp), 8'h01);
    sweep();
    transport = 6'h20;
    tick(2);
    check(arm_lamp, armed);
    panel_partner_i.press(12'h800);
    armed ^= 8'h80;
    check(recording, armed);
    check(monitorInput, armed);
    panel_partner_i.press(12'h002);
    allOn = 1;
    sweep();
    trackCopyMode = 1;
    tick(2);
    allOn = 0;
    check(8'(allLamp), 8'h00);
    panel_partner_i.press(12'h002);
    check(8'(allLamp), 8'h00);
    trackCopyMode = 0;
    panel_partner_i.press({armed, 4'h0});
    armed = '0;
    check(arm_lamp | monitorInput, 8'h00);
    panel_partner_i.press(12'h001);
    check(8'(autoLamp), 8'h00);
    m = 8'($urandom) | 8'h01;
    pulse(m);
    tick(25);
    check(peakLamp, m);
    panel_partner_i.press(12'h008);
    check(peakLamp, 8'h00);
    panel_partner_i.press(12'h004);
    check(8'(holdModeLamp), 8'h02);
    pulse(m);
    tick(8);
    check(peakLamp, m);
    tick(20);
    check(peakLamp, 8'h00);
    pulse(m);
    panel_partner_i.press(12'h008);
    check(peakLamp, 8'h00);
    panel_partner_i.press(12'h004);
    check(8'(holdModeLamp), 8'h04);
    pulse(m);
    tick(2);
    check(peakLamp, 8'h00);
    panel_partner_i.press(12'h008);
    check(8'(holdModeLamp), 8'h04);
    panel_partner_i.press(12'h004);
    check(8'(holdModeLamp), 8'h01);
    panel_partner_i.press(12'h00c);
    check({6'h0, fineMeterMode, fine_scale_message}, 8'h03);
    check(8'(holdModeLamp), 8'h01);
    pulse(m);
    tick(2);
    check(peakLamp, 8'h00);
    panel_partner_i.press(12'h008);
    check({6'h0, fineMeterMode, fine_scale_message}, 8'h00);
    test_done();
  end
endmodule : track_monitor_meter_control_tb
`default_nettype wire
